// file: rtl/bus_xcvr_map.vh
/*
  Constants for the registered bus transceiver: register offsets, field
  positions, reset values and widths.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef BUS_XCVR_MAP_VH
`define BUS_XCVR_MAP_VH

`define XCVR_SLICES 2
`define XCVR_SLICE_W 8
`define XCVR_DATA_W 16
`define XCVR_ADDR_W 8
`define XCVR_RDATA_W 32

`define XCVR_OFS_CTRL 8'h00
`define XCVR_OFS_STORE_ONE 8'h04
`define XCVR_OFS_STORE_TWO 8'h08
`define XCVR_OFS_PINS 8'h0C
`define XCVR_OFS_EVENTS 8'h10

`define XCVR_CTRL_RST 2'h3
`define XCVR_CTRL_DRIVE_LSB 0
`define XCVR_CTRL_DRIVE_MSB 1

`define XCVR_PINS_ONE_TO_TWO_DRIVE_EN_LSB 0
`define XCVR_PINS_TWO_TO_ONE_DRIVE_EN_N_LSB 2
`define XCVR_PINS_SAB_LSB 4
`define XCVR_PINS_SBA_LSB 6
`define XCVR_PINS_DRV1_LSB 8
`define XCVR_PINS_DRV2_LSB 10

`define XCVR_EVT_CNT_W 8
`define XCVR_EVT_CNT_RST 8'h00

`define XCVR_SYNC_STAGES 2

`endif

// file: rtl/xcvr_sync.v
/*
  Two-flop synchroniser for a vector of asynchronous pin levels.
  Assumes each bit is an independent level; only the second stage is read.
*/
`timescale 1ns/10ps
`default_nettype none

module xcvr_sync #(
  parameter WIDTH = 1
) (
  input wire i_clk,
  input wire i_rst_n,
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // First stage feeds the second stage only
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule // xcvr_sync

`default_nettype wire

// file: rtl/xcvr_slice.v
/*
  One 8-bit transceiver slice: two storage registers and the registered
  drivers for port one and port two.
  Assumes all inputs are already synchronised to i_clk and capture events
  arrive as one-cycle pulses aligned with the data.
*/
`timescale 1ns/10ps
`default_nettype none
`include "bus_xcvr_map.vh"

module xcvr_slice (
  input wire i_clk,
  input wire i_rst_n,
  input wire [`XCVR_SLICE_W-1:0] i_one_in,
  input wire [`XCVR_SLICE_W-1:0] i_two_in,
  input wire i_one_to_two_capture,
  input wire i_two_to_one_capture,
  input wire i_one_to_two_drive_en,
  input wire i_two_to_one_drive_en_n,
  input wire i_one_to_two_source_sel,
  input wire i_two_to_one_source_sel,
  input wire i_allow_drive,
  output reg [`XCVR_SLICE_W-1:0] o_one_out,
  output reg o_one_oe_n,
  output reg [`XCVR_SLICE_W-1:0] o_two_out,
  output reg o_two_oe_n,
  output wire [`XCVR_SLICE_W-1:0] o_store_one,
  output wire [`XCVR_SLICE_W-1:0] o_store_two
);

  reg [`XCVR_SLICE_W-1:0] store_ab_q;
  reg [`XCVR_SLICE_W-1:0] store_ba_q;
  wire drive_one;
  wire drive_two;
  wire two_from_one;
  wire one_from_two;
  wire [`XCVR_SLICE_W-1:0] ab_src;
  wire [`XCVR_SLICE_W-1:0] ba_src;

  assign drive_one = i_allow_drive & ~i_two_to_one_drive_en_n;
  assign drive_two = i_allow_drive & i_one_to_two_drive_en;
  assign two_from_one = i_one_to_two_drive_en & i_two_to_one_drive_en_n;
  assign one_from_two = ~i_one_to_two_drive_en & ~i_two_to_one_drive_en_n;

  // Bus turnaround lag would otherwise store stale data in the far register
  assign ab_src = one_from_two ? i_two_in : i_one_in;
  assign ba_src = two_from_one ? i_one_in : i_two_in;

  // Storage has no reset: contents undefined until first capture
  always @(posedge i_clk) begin
    if (i_one_to_two_capture) begin
      store_ab_q <= ab_src;
    end
    if (i_two_to_one_capture) begin
      store_ba_q <= ba_src;
    end
  end

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_one_out <= 8'h00;
      o_two_out <= 8'h00;
      o_one_oe_n <= 1'b1;
      o_two_oe_n <= 1'b1;
    end else begin
      o_one_oe_n <= ~drive_one;
      o_two_oe_n <= ~drive_two;
      // Live path echoes the opposite bus, so both enabled acts as a keeper
      o_one_out <= i_two_to_one_source_sel ? store_ba_q : i_two_in;
      o_two_out <= i_one_to_two_source_sel ? store_ab_q : i_one_in;
    end
  end

  assign o_store_one = store_ab_q;
  assign o_store_two = store_ba_q;

endmodule // xcvr_slice

`default_nettype wire

// file: rtl/bus_xcvr.v
/*
  Sixteen-bit registered bus transceiver made of two independent slices,
  with a small register port for drive gating and read-back.
  Assumes all pins but the register port are asynchronous to i_clk and pass two flops; capture
  clocks are sampled as levels, so each must stay high and low for at least
  two i_clk periods. Port pins are split into in, out and enable-low.
*/
// Local design decisions: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "bus_xcvr_map.vh"

module bus_xcvr (
  input wire i_clk,
  input wire i_rst_n,
  input wire [`XCVR_DATA_W-1:0] i_port_one,
  output wire [`XCVR_DATA_W-1:0] o_port_one,
  output wire [`XCVR_SLICES-1:0] o_port_one_oe_n,
  input wire [`XCVR_DATA_W-1:0] i_port_two,
  output wire [`XCVR_DATA_W-1:0] o_port_two,
  output wire [`XCVR_SLICES-1:0] o_port_two_oe_n,
  input wire [`XCVR_SLICES-1:0] i_one_to_two_capture_clock,
  input wire [`XCVR_SLICES-1:0] i_two_to_one_capture_clock,
  input wire [`XCVR_SLICES-1:0] i_one_to_two_drive_en,
  input wire [`XCVR_SLICES-1:0] i_two_to_one_drive_en_n,
  input wire [`XCVR_SLICES-1:0] i_one_to_two_source_sel,
  input wire [`XCVR_SLICES-1:0] i_two_to_one_source_sel,
  input wire [`XCVR_ADDR_W-1:0] i_addr,
  input wire [`XCVR_RDATA_W-1:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [`XCVR_RDATA_W-1:0] o_rdata
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  localparam CTL_W = 6 * `XCVR_SLICES;

  wire [`XCVR_DATA_W-1:0] one_s;
  wire [`XCVR_DATA_W-1:0] two_s;
  wire [CTL_W-1:0] ctl_s;
  wire [`XCVR_SLICES-1:0] clk_ab_s;
  wire [`XCVR_SLICES-1:0] clk_ba_s;
  wire [`XCVR_SLICES-1:0] one_to_two_drive_en_s;
  wire [`XCVR_SLICES-1:0] two_to_one_drive_en_n_n_s;
  wire [`XCVR_SLICES-1:0] sab_s;
  wire [`XCVR_SLICES-1:0] sba_s;

  xcvr_sync #(
    .WIDTH(`XCVR_DATA_W)
  ) u_sync_one (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_port_one),
    .o_sync(one_s)
  );

  xcvr_sync #(
    .WIDTH(`XCVR_DATA_W)
  ) u_sync_two (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async(i_port_two),
    .o_sync(two_s)
  );

  // Enable-low pins must not glitch active while syncing out of reset
  xcvr_sync #(
    .WIDTH(CTL_W)
  ) u_sync_ctl (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_one_to_two_capture_clock, i_two_to_one_capture_clock,
              i_one_to_two_drive_en, ~i_two_to_one_drive_en_n,
              i_one_to_two_source_sel, i_two_to_one_source_sel}),
    .o_sync(ctl_s)
  );

  assign clk_ab_s = ctl_s[6*`XCVR_SLICES-1:5*`XCVR_SLICES];
  assign clk_ba_s = ctl_s[5*`XCVR_SLICES-1:4*`XCVR_SLICES];
  assign one_to_two_drive_en_s = ctl_s[4*`XCVR_SLICES-1:3*`XCVR_SLICES];
  assign two_to_one_drive_en_n_n_s = ~ctl_s[3*`XCVR_SLICES-1:2*`XCVR_SLICES];
  assign sab_s = ctl_s[2*`XCVR_SLICES-1:`XCVR_SLICES];
  assign sba_s = ctl_s[`XCVR_SLICES-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Capture edge detection

  reg [`XCVR_SLICES-1:0] clk_ab_prev_q;
  reg [`XCVR_SLICES-1:0] clk_ba_prev_q;
  wire [`XCVR_SLICES-1:0] cap_ab;
  wire [`XCVR_SLICES-1:0] cap_ba;

  // Reset high, but the sync flops reset low, so a clock pin held high at release still gives one edge
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_ab_prev_q <= {`XCVR_SLICES{1'b1}};
      clk_ba_prev_q <= {`XCVR_SLICES{1'b1}};
    end else begin
      clk_ab_prev_q <= clk_ab_s;
      clk_ba_prev_q <= clk_ba_s;
    end
  end

  assign cap_ab = clk_ab_s & ~clk_ab_prev_q;
  assign cap_ba = clk_ba_s & ~clk_ba_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Register port

  reg [`XCVR_SLICES-1:0] ctrl_q;
  reg [`XCVR_EVT_CNT_W-1:0] evt_ab_q [0:`XCVR_SLICES-1];
  reg [`XCVR_EVT_CNT_W-1:0] evt_ba_q [0:`XCVR_SLICES-1];
  wire [`XCVR_DATA_W-1:0] store_one;
  wire [`XCVR_DATA_W-1:0] store_two;
  wire evt_clear;
  reg [`XCVR_RDATA_W-1:0] rdata_d;

  function hit;
    input [`XCVR_ADDR_W-1:0] addr;
    input [`XCVR_ADDR_W-1:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  assign evt_clear = i_wr & hit(i_addr, `XCVR_OFS_EVENTS);

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= `XCVR_CTRL_RST;
    end else if (i_wr & hit(i_addr, `XCVR_OFS_CTRL)) begin
      ctrl_q <= i_wdata[`XCVR_CTRL_DRIVE_MSB:`XCVR_CTRL_DRIVE_LSB];
    end
  end

  always @* begin
    rdata_d = 32'h0000_0000;
    case (i_addr)
      `XCVR_OFS_CTRL: begin
        rdata_d[`XCVR_CTRL_DRIVE_MSB:`XCVR_CTRL_DRIVE_LSB] = ctrl_q;
      end
      `XCVR_OFS_STORE_ONE: begin
        rdata_d[`XCVR_DATA_W-1:0] = store_one;
      end
      `XCVR_OFS_STORE_TWO: begin
        rdata_d[`XCVR_DATA_W-1:0] = store_two;
      end
      `XCVR_OFS_PINS: begin
        rdata_d[`XCVR_PINS_ONE_TO_TWO_DRIVE_EN_LSB+1:`XCVR_PINS_ONE_TO_TWO_DRIVE_EN_LSB] = one_to_two_drive_en_s;
        rdata_d[`XCVR_PINS_TWO_TO_ONE_DRIVE_EN_N_LSB+1:`XCVR_PINS_TWO_TO_ONE_DRIVE_EN_N_LSB] = two_to_one_drive_en_n_n_s;
        rdata_d[`XCVR_PINS_SAB_LSB+1:`XCVR_PINS_SAB_LSB] = sab_s;
        rdata_d[`XCVR_PINS_SBA_LSB+1:`XCVR_PINS_SBA_LSB] = sba_s;
        rdata_d[`XCVR_PINS_DRV1_LSB+1:`XCVR_PINS_DRV1_LSB] = ~o_port_one_oe_n;
        rdata_d[`XCVR_PINS_DRV2_LSB+1:`XCVR_PINS_DRV2_LSB] = ~o_port_two_oe_n;
      end
      `XCVR_OFS_EVENTS: begin
        rdata_d = {evt_ba_q[1], evt_ab_q[1], evt_ba_q[0], evt_ab_q[0]};
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      o_rdata <= rdata_d;
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slices

  genvar g;
  generate
    for (g = 0; g < `XCVR_SLICES; g = g + 1) begin : g_slice
      // A capture landing with the clear counts as one, so no edge is lost
      always @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          evt_ab_q[g] <= `XCVR_EVT_CNT_RST;
          evt_ba_q[g] <= `XCVR_EVT_CNT_RST;
        end else begin
          if (evt_clear) begin
            evt_ab_q[g] <= {{(`XCVR_EVT_CNT_W-1){1'b0}}, cap_ab[g]};
            evt_ba_q[g] <= {{(`XCVR_EVT_CNT_W-1){1'b0}}, cap_ba[g]};
          end else begin
            evt_ab_q[g] <= evt_ab_q[g] + {{(`XCVR_EVT_CNT_W-1){1'b0}}, cap_ab[g]};
            evt_ba_q[g] <= evt_ba_q[g] + {{(`XCVR_EVT_CNT_W-1){1'b0}}, cap_ba[g]};
          end
        end
      end

      xcvr_slice u_slice (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_one_in(one_s[g*`XCVR_SLICE_W +: `XCVR_SLICE_W]),
        .i_two_in(two_s[g*`XCVR_SLICE_W +: `XCVR_SLICE_W]),
        .i_one_to_two_capture(cap_ab[g]),
        .i_two_to_one_capture(cap_ba[g]),
        .i_one_to_two_drive_en(one_to_two_drive_en_s[g]),
        .i_two_to_one_drive_en_n(two_to_one_drive_en_n_n_s[g]),
        .i_one_to_two_source_sel(sab_s[g]),
        .i_two_to_one_source_sel(sba_s[g]),
        .i_allow_drive(ctrl_q[g]),
        .o_one_out(o_port_one[g*`XCVR_SLICE_W +: `XCVR_SLICE_W]),
        .o_one_oe_n(o_port_one_oe_n[g]),
        .o_two_out(o_port_two[g*`XCVR_SLICE_W +: `XCVR_SLICE_W]),
        .o_two_oe_n(o_port_two_oe_n[g]),
        .o_store_one(store_one[g*`XCVR_SLICE_W +: `XCVR_SLICE_W]),
        .o_store_two(store_two[g*`XCVR_SLICE_W +: `XCVR_SLICE_W])
      );
    end
  endgenerate

endmodule // bus_xcvr

`default_nettype wire

// file: testbench/xcvr_checker.sv
/* Port-level assertions for bus_xcvr.
   Assumes a three-edge pin latency and is bound to every bus_xcvr. */
`timescale 1ns/10ps
`default_nettype none
module xcvr_checker (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_port_one,
  input wire logic [15:0] i_port_two,
  input wire logic [15:0] o_port_one,
  input wire logic [15:0] o_port_two,
  input wire logic [1:0] o_port_one_oe_n,
  input wire logic [1:0] o_port_two_oe_n,
  input wire logic [1:0] i_one_to_two_drive_en,
  input wire logic [1:0] i_two_to_one_drive_en_n,
  input wire logic [1:0] i_one_to_two_source_sel,
  input wire logic [1:0] i_two_to_one_source_sel,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata
);
  logic [2:0] age_q;
  // Sync pipes still hold reset values just after release
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      age_q <= 3'h0;
    end else if (!age_q[2]) begin
      age_q <= age_q + 3'h1;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_one_oe;
    age_q[2] |-> (~o_port_one_oe_n & $past(i_two_to_one_drive_en_n, 3)) == 2'h0;
  endproperty
  a_one_oe: assert property (p_one_oe) else $error("port one driven while off");
  property p_two_oe;
    age_q[2] |-> (~o_port_two_oe_n & ~$past(i_one_to_two_drive_en, 3)) == 2'h0;
  endproperty
  a_two_oe: assert property (p_two_oe) else $error("port two driven while off");
  property p_live_one;
    age_q[2] && !o_port_one_oe_n[0] && !$past(i_two_to_one_source_sel[0], 3)
      |-> o_port_one[7:0] == $past(i_port_two[7:0], 3);
  endproperty
  a_live_one: assert property (p_live_one) else $error("port one live data wrong");
  property p_live_two;
    age_q[2] && !o_port_two_oe_n[0] && !$past(i_one_to_two_source_sel[0], 3)
      |-> o_port_two[7:0] == $past(i_port_one[7:0], 3);
  endproperty
  a_live_two: assert property (p_live_two) else $error("port two live data wrong");
  property p_rd_idle;
    !$past(i_rd) |-> o_rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  property p_ctrl_back;
    (i_wr && i_addr == 8'h00) ##1 (!i_wr && !i_rd) ##1 (i_rd && i_addr == 8'h00)
      |=> o_rdata[1:0] == $past(i_wdata[1:0], 3);
  endproperty
  a_ctrl_back: assert property (p_ctrl_back) else $error("control read-back wrong");
  property p_unmapped;
    i_rd && i_addr > 8'h10 |=> o_rdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_gate;
    i_wr && i_addr == 8'h00 && i_wdata[1:0] == 2'h0 |-> ##3 (&o_port_one_oe_n && &o_port_two_oe_n);
  endproperty
  a_gate: assert property (p_gate) else $error("drive not gated off");
endmodule // xcvr_checker
bind bus_xcvr xcvr_checker i_chk (.i_clk, .i_rst_n, .i_port_one, .i_port_two, .o_port_one, .o_port_two,
  .o_port_one_oe_n, .o_port_two_oe_n, .i_one_to_two_drive_en, .i_two_to_one_drive_en_n,
  .i_one_to_two_source_sel, .i_two_to_one_source_sel, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata);
`default_nettype wire

// file: testbench/bus_partner.sv
/* Far-side logic on both port buses, resolving each wire per slice.
   Where the bench and the device both drive a slice, the bench value wins. */
`timescale 1ns/10ps
`default_nettype none
module bus_partner (
  input wire logic i_clk,
  input wire logic [15:0] i_dev_one,
  input wire logic [1:0] i_dev_one_oe_n,
  input wire logic [15:0] i_dev_two,
  input wire logic [1:0] i_dev_two_oe_n,
  input wire logic [15:0] i_far_one,
  input wire logic [1:0] i_far_one_en,
  input wire logic [15:0] i_far_two,
  input wire logic [1:0] i_far_two_en,
  output logic [15:0] o_bus_one,
  output logic [15:0] o_bus_two
);
  logic [15:0] one_q;
  logic [15:0] two_q;
  // Undriven wire has no pull: show a changing pattern, not a held value
  function automatic logic [7:0] pick(input logic fe, input logic [7:0] f, input logic oe_n,
                                      input logic [7:0] d, input logic [7:0] last);
    pick = fe ? f : (!oe_n ? d : ~last);
  endfunction
  assign o_bus_one = {pick(i_far_one_en[1], i_far_one[15:8], i_dev_one_oe_n[1], i_dev_one[15:8], one_q[15:8]),
                      pick(i_far_one_en[0], i_far_one[7:0], i_dev_one_oe_n[0], i_dev_one[7:0], one_q[7:0])};
  assign o_bus_two = {pick(i_far_two_en[1], i_far_two[15:8], i_dev_two_oe_n[1], i_dev_two[15:8], two_q[15:8]),
                      pick(i_far_two_en[0], i_far_two[7:0], i_dev_two_oe_n[0], i_dev_two[7:0], two_q[7:0])};
  always @(posedge i_clk) begin
    one_q <= o_bus_one;
    two_q <= o_bus_two;
  end
endmodule // bus_partner
`default_nettype wire

// file: testbench/tb_top.sv
/* Self-checking bench for bus_xcvr, one task per scenario.
   Assumes bus_partner resolves the buses and the checker is bound. */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [15:0] f1 = 16'h0000, f2 = 16'h0000, b1, b2, d1, d2;
  logic [1:0] f1e = 2'h3, f2e = 2'h3, c12 = 2'h0, c21 = 2'h0, oe1, oe2;
  logic [1:0] en = 2'h0, en_n = 2'h3, s12 = 2'h0, s21 = 2'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, rdata;
  logic wr = 1'b0, rd = 1'b0;
  int bad_count = 0, checks = 0;
  always #50 i_clk = ~i_clk;
  bus_xcvr i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_port_one(b1), .o_port_one(d1), .o_port_one_oe_n(oe1),
    .i_port_two(b2), .o_port_two(d2), .o_port_two_oe_n(oe2), .i_one_to_two_capture_clock(c12),
    .i_two_to_one_capture_clock(c21), .i_one_to_two_drive_en(en), .i_two_to_one_drive_en_n(en_n),
    .i_one_to_two_source_sel(s12), .i_two_to_one_source_sel(s21), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata));
  bus_partner i_far (.i_clk(i_clk), .i_dev_one(d1), .i_dev_one_oe_n(oe1), .i_dev_two(d2), .i_dev_two_oe_n(oe2),
    .i_far_one(f1), .i_far_one_en(f1e), .i_far_two(f2), .i_far_two_en(f2e), .o_bus_one(b1), .o_bus_two(b2));
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge i_clk);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_clk);
    rd <= 1'b0;
    #10 chk(rdata, exp);
    @(posedge i_clk);
  endtask
  // Pins pass two sync flops, so every change is held six cycles
  task automatic set(input logic [1:0] e, input logic [1:0] e_n, input logic [1:0] a, input logic [1:0] b,
                     input logic [1:0] fe1, input logic [1:0] fe2, input logic [15:0] v1, input logic [15:0] v2);
    en <= e;
    en_n <= e_n;
    s12 <= a;
    s21 <= b;
    f1e <= fe1;
    f2e <= fe2;
    f1 <= v1;
    f2 <= v2;
    cyc(6);
  endtask
  task automatic cap(input logic [1:0] m12, input logic [1:0] m21);
    c12 <= m12;
    c21 <= m21;
    cyc(3);
    c12 <= 2'h0;
    c21 <= 2'h0;
    cyc(4);
  endtask
  task automatic t_isol;
    set(2'h0, 2'h3, 2'h0, 2'h0, 2'h3, 2'h3, 16'hA51C, 16'h3C96);
    cap(2'h3, 2'h3);
    chk({28'h000_0000, oe1, oe2}, 32'h0000_000F);
    set(2'h0, 2'h3, 2'h0, 2'h0, 2'h3, 2'h3, 16'h0F0F, 16'h7E81);
    cap(2'h2, 2'h1);
    rd_chk(8'h04, 32'h0000_0F1C);
    rd_chk(8'h08, 32'h0000_3C81);
    rd_chk(8'h0C, 32'h0000_000C);
    rd_chk(8'h10, 32'h0102_0201);
    wr_reg(8'h10, 32'h0000_0000);
    rd_chk(8'h10, 32'h0000_0000);
  endtask
  task automatic t_both;
    set(2'h3, 2'h0, 2'h3, 2'h3, 2'h0, 2'h0, 16'h0000, 16'h0000);
    chk({16'h0000, b1}, 32'h0000_3C81);
    chk({16'h0000, b2}, 32'h0000_0F1C);
    rd_chk(8'h0C, 32'h0000_0FF3);
  endtask
  task automatic t_regs;
    rd_chk(8'h00, 32'h0000_0003);
    wr_reg(8'h00, 32'h0000_0000);
    rd_chk(8'h00, 32'h0000_0000);
    cyc(3);
    chk({28'h000_0000, oe1, oe2}, 32'h0000_000F);
    wr_reg(8'h20, 32'h0000_0003);
    rd_chk(8'h20, 32'h0000_0000);
    rd_chk(8'h00, 32'h0000_0000);
    wr_reg(8'h00, 32'h0000_0003);
    cyc(5);
    chk({28'h000_0000, oe1, oe2}, 32'h0000_0000);
  endtask
  task automatic t_a2b;
    set(2'h3, 2'h3, 2'h0, 2'h0, 2'h3, 2'h0, 16'h6B2D, 16'h0000);
    chk({16'h0000, b2}, 32'h0000_6B2D);
    cap(2'h3, 2'h3);
    rd_chk(8'h04, 32'h0000_6B2D);
    rd_chk(8'h08, 32'h0000_6B2D);
    set(2'h3, 2'h3, 2'h3, 2'h0, 2'h3, 2'h0, 16'h1111, 16'h0000);
    chk({16'h0000, b2}, 32'h0000_6B2D);
  endtask
  task automatic t_b2a;
    set(2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 16'h0000, 16'hD24E);
    chk({16'h0000, b1}, 32'h0000_D24E);
    cap(2'h3, 2'h3);
    rd_chk(8'h04, 32'h0000_D24E);
    rd_chk(8'h08, 32'h0000_D24E);
    set(2'h0, 2'h0, 2'h0, 2'h3, 2'h0, 2'h3, 16'h0000, 16'h2222);
    chk({16'h0000, b1}, 32'h0000_D24E);
  endtask
  task automatic t_keep;
    set(2'h3, 2'h0, 2'h0, 2'h0, 2'h3, 2'h0, 16'h5AC3, 16'h0000);
    set(2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 16'h5AC3, 16'h0000);
    cyc(4);
    chk({b1, b2}, 32'h5AC3_5AC3);
  endtask
  task automatic results;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    cyc(16);
    i_rst_n <= 1'b1;
    cyc(4);
    t_isol();
    t_both();
    t_regs();
    t_a2b();
    t_b2a();
    t_keep();
    results();
  end
endmodule // tb_top
`default_nettype wire
